/* dtm_pkg.sv */
// Shared constants and types for the dual channel temperature monitor
package dtm_pkg;
  // Core clock and the times that the logic counts
  localparam int CORE_CLK_HZ = 100_000_000;
  localparam int SLOT_MS = 125;
  localparam int SLOT_CYCLES = CORE_CLK_HZ / 1000 * SLOT_MS;
  localparam int TIMEOUT_MS = 20;
  localparam int TIMEOUT_CYCLES = CORE_CLK_HZ / 1000 * TIMEOUT_MS;
  localparam int TIMER_W = 24;

  // Converter result: eight whole bits over two fraction bits
  localparam int RES_W = 10;
  localparam int FRAC_W = 2;

  // Command byte values, which are also the register pointers
  localparam logic [7:0] REG_LOC_WHOLE = 8'h00;
  localparam logic [7:0] REG_REM_WHOLE = 8'h01;
  localparam logic [7:0] REG_STATUS = 8'h02;
  localparam logic [7:0] REG_CFG_RD = 8'h03;
  localparam logic [7:0] REG_LOC_LIM_RD = 8'h05;
  localparam logic [7:0] REG_REM_LIM_RD = 8'h07;
  localparam logic [7:0] REG_CFG_WR = 8'h09;
  localparam logic [7:0] REG_LOC_LIM_WR = 8'h0B;
  localparam logic [7:0] REG_REM_LIM_WR = 8'h0D;
  localparam logic [7:0] REG_ONE_SHOT = 8'h0F;
  localparam logic [7:0] REG_REM_FRAC = 8'h10;
  localparam logic [7:0] REG_LOC_FRAC = 8'h11;
  localparam logic [7:0] REG_ID = 8'hFE;

  // Reset values
  localparam logic [7:0] TEMP_RESET = 8'h00;
  localparam logic [7:0] CFG_RESET = 8'h10;
  localparam logic [7:0] LOC_LIM_RESET = 8'h46;
  localparam logic [7:0] REM_LIM_RESET = 8'h78;

  // Field positions
  localparam int CFG_STBY_BIT = 6;
  localparam int CFG_REM_ONLY_BIT = 5;
  localparam int ST_LOC_HIGH_BIT = 6;
  localparam int ST_REM_HIGH_BIT = 4;

  // Bus addresses
  localparam logic [6:0] ALERT_RESP_ADDR = 7'h0C;

  // Serial slave states
  typedef enum logic [2:0] {
    BS_IDLE = 3'b000,
    BS_ADDR = 3'b001,
    BS_CMD = 3'b010,
    BS_WDATA = 3'b011,
    BS_RDATA = 3'b100,
    BS_ACK_OUT = 3'b101,
    BS_ACK_IN = 3'b110
  } dtm_bus_state_t;

  // Conversion sequencer states
  typedef enum logic {
    SQ_IDLE = 1'b0,
    SQ_CONV = 1'b1
  } dtm_seq_state_t;
endpackage

/* dtm_link.sv */
// Converter-side end of the result handshake, on the converter's own clock
`timescale 1ns/1ps
module dtm_link
  import dtm_pkg::*;
(
  input wire logic adc_clk,
  input wire logic rst_b,
  input wire logic req_tgl,
  input wire logic req_ch,
  input wire logic adc_done,
  input wire logic [RES_W-1:0] adc_data,
  output logic adc_start,
  output logic adc_chan,
  output logic [RES_W-1:0] res_data,
  output logic ack_tgl
);
  logic [1:0] req_sync;
  logic req_prev;
  logic wait_res;
  logic req_edge;

  // Request toggle passes two flops, a third one finds its edge
  always_ff @(posedge adc_clk or negedge rst_b) begin
    if (!rst_b) begin
      req_sync <= 2'b00;
      req_prev <= 1'b0;
    end else begin
      req_sync <= {req_sync[0], req_tgl};
      req_prev <= req_sync[1];
    end
  end

  assign req_edge = req_sync[1] ^ req_prev;

  // Start the converter; the channel is stable while a request is open
  always_ff @(posedge adc_clk or negedge rst_b) begin
    if (!rst_b) begin
      adc_start <= 1'b0;
      adc_chan <= 1'b0;
    end else begin
      adc_start <= req_edge;
      if (req_edge) begin
        adc_chan <= req_ch;
      end
    end
  end

  // Hold the result word and flip the answer toggle in the same cycle
  always_ff @(posedge adc_clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_res <= 1'b0;
      res_data <= '0;
      ack_tgl <= 1'b0;
    end else begin
      if (req_edge) begin
        wait_res <= 1'b1;
      end else if (adc_done && wait_res) begin
        wait_res <= 1'b0;
        res_data <= adc_data;  // Stays put until the next result arrives
        ack_tgl <= ~ack_tgl;
      end
    end
  end
endmodule

/* dtm_top.sv */
// Top of the dual channel temperature monitor: serial slave, registers, sequencer
`timescale 1ns/1ps
// Notes on behaviour
// (R1) Convert free-running eight per second, or single shot
// (R2) Whole-degree results at 00h and 01h
// (R3) Fraction bits at 10h and 11h
// (R4) Every conversion run covers both channels, except free-running remote-only
// (R5) Unused local channel is not measured in free-running remote-only mode
// (R6) Each channel slot lasts 125 ms
// (R7) Both channels alternate, four each per second
// (R8) Remote-only option: remote eight times per second
// (R9) Reads return the last completed result
// (R10) Standby bit stops converter and its timing
// (R11) Standby keeps registers and serial interface alive
// (R12) Single shot runs even in standby
// (R13) Standby aborts conversion, old results stay
// (R14) Byte-wide registers reached over two-wire interface
// (R15) Only Write, Read, Send, Receive Byte
// (R16) Alert when a reading exceeds its limit
// (R17) Alert output only pulls low
// (R18) Data line only pulls low
// (R19) Interface resets on long clock-low period
// (R20) Pointer kept for later Receive Byte reads
// (R21) Alert latched until status read or response
// (R22) Whole and fraction registers update together
// (R23) Fraction sits in the top two bits
// (R24) Clearing standby resumes free-running conversion
module dtm_top
  import dtm_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = 7'h4C,
  parameter logic [7:0] ID_CODE = 8'h5A,  // Arbitrary identity value
  parameter int SLOT_CYC = SLOT_CYCLES,
  parameter int TIMEOUT_CYC = TIMEOUT_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic scl,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic alert_o,
  output logic alert_oe,
  input wire logic adc_clk,
  input wire logic adc_done,
  input wire logic [RES_W-1:0] adc_data,
  output logic adc_start,
  output logic adc_chan
);
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic scl_prev;
  logic sda_prev;
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic [TIMER_W-1:0] low_cnt;
  logic bus_timeout;
  dtm_bus_state_t bus_state;
  dtm_bus_state_t after_ack;
  logic [2:0] bit_cnt;
  logic byte_done;
  logic [7:0] rx_sh;
  logic [7:0] tx_sh;
  logic [7:0] tx_next;
  logic [7:0] ptr;
  logic is_ara;
  logic nack;
  logic reg_wr;
  logic cmd_shot;
  logic status_rd;
  logic ara_done;
  logic [7:0] cfg;
  logic [7:0] loc_lim;
  logic [7:0] rem_lim;
  logic [7:0] loc_whole;
  logic [7:0] rem_whole;
  logic [7:0] loc_frac;
  logic [7:0] rem_frac;
  logic [7:0] rd_byte;
  logic [7:0] status_byte;
  logic st_loc;
  logic st_rem;
  logic standby;
  logic remote_only;
  logic abort;
  dtm_seq_state_t seq_state;
  logic [TIMER_W-1:0] slot_cnt;
  logic cur_ch;
  logic shot_mode;
  logic slot_begin;
  logic req_tgl;
  logic req_ch;
  logic keep;
  logic [1:0] ack_sync;
  logic ack_prev;
  logic ack_edge;
  logic busy;
  logic commit;
  logic link_ack;
  logic [RES_W-1:0] res_data;
  logic [7:0] res_whole;
  logic loc_hot_new;
  logic rem_hot_new;
  logic loc_over;
  logic rem_over;

  // Bus pins come from another domain: two flops, then one for edges
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_sync <= 2'b11;
      sda_sync <= 2'b11;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], scl};
      sda_sync <= {sda_sync[0], sda_i};
      scl_prev <= scl_sync[1];
      sda_prev <= sda_sync[1];
    end
  end

  // Bus events; start and stop are data changes while the clock is high
  assign scl_s = scl_sync[1];
  assign sda_s = sda_sync[1];
  assign scl_rise = scl_s & ~scl_prev;
  assign scl_fall = ~scl_s & scl_prev;
  assign bus_start = scl_s & scl_prev & sda_prev & ~sda_s;
  assign bus_stop = scl_s & scl_prev & ~sda_prev & sda_s;

  // Clock-low watchdog; saturates so the reset fires once per stall
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      low_cnt <= '0;
    end else if (scl_s) begin
      low_cnt <= '0;
    end else if (low_cnt != TIMER_W'(TIMEOUT_CYC)) begin
      low_cnt <= low_cnt + TIMER_W'(1);
    end
  end

  assign bus_timeout = ~scl_s && (low_cnt == TIMER_W'(TIMEOUT_CYC - 1));  // see (R19)

  // Byte to send: own address for the alert response, else the register
  assign tx_next = is_ara ? {SLAVE_ADDR, 1'b0} : rd_byte;

  // Serial slave; sda_oe high pulls the line low, it never drives high
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_state <= BS_IDLE;
      after_ack <= BS_IDLE;
      bit_cnt <= 3'h0;
      byte_done <= 1'b0;
      rx_sh <= 8'h00;
      tx_sh <= 8'h00;
      ptr <= REG_LOC_WHOLE;
      is_ara <= 1'b0;
      nack <= 1'b0;
      sda_oe <= 1'b0;
      reg_wr <= 1'b0;
      cmd_shot <= 1'b0;
      status_rd <= 1'b0;
      ara_done <= 1'b0;
    end else begin
      reg_wr <= 1'b0;
      cmd_shot <= 1'b0;
      status_rd <= 1'b0;
      ara_done <= 1'b0;
      if (bus_timeout || bus_stop) begin
        bus_state <= BS_IDLE;  // see (R19)
        sda_oe <= 1'b0;
      end else if (bus_start) begin
        bus_state <= BS_ADDR;
        bit_cnt <= 3'h0;
        byte_done <= 1'b0;
        sda_oe <= 1'b0;
      end else if (scl_rise) begin
        case (bus_state)
          BS_ADDR, BS_CMD, BS_WDATA, BS_RDATA: begin
            rx_sh <= {rx_sh[6:0], sda_s};
            bit_cnt <= bit_cnt + 3'h1;
            byte_done <= (bit_cnt == 3'h7);
          end
          BS_ACK_IN: begin
            nack <= sda_s;
          end
          default: begin
          end
        endcase
      end else if (scl_fall) begin
        case (bus_state)
          BS_ADDR: begin
            if (byte_done) begin
              byte_done <= 1'b0;
              if (rx_sh[7:1] == SLAVE_ADDR ||
                  (rx_sh[7:1] == ALERT_RESP_ADDR && rx_sh[0] && alert_oe)) begin
                sda_oe <= 1'b1;
                is_ara <= (rx_sh[7:1] != SLAVE_ADDR);
                after_ack <= rx_sh[0] ? BS_RDATA : BS_CMD;  // see (R15)
                bus_state <= BS_ACK_OUT;
              end else begin
                bus_state <= BS_IDLE;
              end
            end
          end
          BS_CMD: begin
            if (byte_done) begin
              byte_done <= 1'b0;
              ptr <= rx_sh;  // see (R20)
              cmd_shot <= (rx_sh == REG_ONE_SHOT);  // see (R12)
              sda_oe <= 1'b1;
              after_ack <= BS_WDATA;
              bus_state <= BS_ACK_OUT;
            end
          end
          BS_WDATA: begin
            if (byte_done) begin
              byte_done <= 1'b0;
              reg_wr <= 1'b1;  // see (R15)
              sda_oe <= 1'b1;
              after_ack <= BS_WDATA;
              bus_state <= BS_ACK_OUT;
            end
          end
          BS_ACK_OUT: begin
            bus_state <= after_ack;
            bit_cnt <= 3'h0;
            if (after_ack == BS_RDATA) begin
              tx_sh <= tx_next;
              sda_oe <= ~tx_next[7];  // see (R18)
              status_rd <= ~is_ara && (ptr == REG_STATUS);
              ara_done <= is_ara;
            end else begin
              sda_oe <= 1'b0;
            end
          end
          BS_RDATA: begin
            if (byte_done) begin
              byte_done <= 1'b0;
              sda_oe <= 1'b0;
              bus_state <= BS_ACK_IN;
            end else begin
              tx_sh <= {tx_sh[6:0], 1'b0};
              sda_oe <= ~tx_sh[6];  // see (R18)
            end
          end
          BS_ACK_IN: begin
            if (nack) begin
              bus_state <= BS_IDLE;
            end else begin
              bus_state <= BS_RDATA;
              bit_cnt <= 3'h0;
              tx_sh <= tx_next;
              sda_oe <= ~tx_next[7];
            end
          end
          default: begin
            bus_state <= BS_IDLE;
          end
        endcase
      end
    end
  end

  // Pin data levels are fixed low; only the enables move
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sda_o <= 1'b0;
      alert_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;  // see (R18)
      alert_o <= 1'b0;  // see (R17)
    end
  end

  // Writable registers; the bus keeps running whatever standby holds
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg <= CFG_RESET;
      loc_lim <= LOC_LIM_RESET;
      rem_lim <= REM_LIM_RESET;
    end else if (reg_wr) begin
      case (ptr)  // see (R14) (R11)
        REG_CFG_WR: cfg <= rx_sh;
        REG_LOC_LIM_WR: loc_lim <= rx_sh;
        REG_REM_LIM_WR: rem_lim <= rx_sh;
        default: begin
        end
      endcase
    end
  end

  assign standby = cfg[CFG_STBY_BIT];
  assign remote_only = cfg[CFG_REM_ONLY_BIT];
  // A standby write mid-run cuts the run short
  assign abort = reg_wr && (ptr == REG_CFG_WR) && rx_sh[CFG_STBY_BIT] &&
                 (seq_state == SQ_CONV);  // see (R13)

  // Status byte gathers the sticky over-limit flags
  always_comb begin
    status_byte = 8'h00;
    status_byte[ST_LOC_HIGH_BIT] = st_loc;
    status_byte[ST_REM_HIGH_BIT] = st_rem;
  end

  // Register read mux
  always_comb begin
    case (ptr)
      REG_LOC_WHOLE: rd_byte = loc_whole;  // see (R2) (R9)
      REG_REM_WHOLE: rd_byte = rem_whole;  // see (R2)
      REG_STATUS: rd_byte = status_byte;
      REG_CFG_RD: rd_byte = cfg;
      REG_LOC_LIM_RD: rd_byte = loc_lim;
      REG_REM_LIM_RD: rd_byte = rem_lim;
      REG_REM_FRAC: rd_byte = rem_frac;  // see (R3)
      REG_LOC_FRAC: rd_byte = loc_frac;  // see (R3)
      REG_ID: rd_byte = ID_CODE;
      default: rd_byte = 8'h00;
    endcase
  end

  // Sequencer: one 125 ms slot per channel; standby holds it idle except for a single shot
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      seq_state <= SQ_IDLE;
      slot_cnt <= '0;
      cur_ch <= 1'b0;
      shot_mode <= 1'b0;
      slot_begin <= 1'b0;
    end else begin
      slot_begin <= 1'b0;
      case (seq_state)
        SQ_IDLE: begin
          if (cmd_shot || !standby) begin  // see (R1) (R12) (R24) (R10)
            seq_state <= SQ_CONV;
            slot_cnt <= TIMER_W'(SLOT_CYC - 1);
            cur_ch <= remote_only & ~cmd_shot;  // see (R4)
            shot_mode <= cmd_shot;
            slot_begin <= 1'b1;
          end
        end
        SQ_CONV: begin
          if (abort) begin
            seq_state <= SQ_IDLE;  // see (R13) (R10)
          end else if (cmd_shot) begin
            slot_cnt <= TIMER_W'(SLOT_CYC - 1);  // Restart from the local slot
            cur_ch <= 1'b0;
            shot_mode <= 1'b1;
            slot_begin <= 1'b1;
          end else if (slot_cnt == '0) begin
            if (shot_mode && cur_ch) begin
              seq_state <= SQ_IDLE;  // Single shot ends after the remote slot
            end else begin
              slot_cnt <= TIMER_W'(SLOT_CYC - 1);  // see (R6)
              cur_ch <= (remote_only & ~shot_mode) | ~cur_ch;  // see (R7) (R8) (R5)
              slot_begin <= 1'b1;
            end
          end else begin
            slot_cnt <= slot_cnt - TIMER_W'(1);
          end
        end
        default: begin
          seq_state <= SQ_IDLE;
        end
      endcase
    end
  end

  // Answer toggle from the converter domain: two flops, then edge
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_sync <= 2'b00;
      ack_prev <= 1'b0;
    end else begin
      ack_sync <= {ack_sync[0], link_ack};
      ack_prev <= ack_sync[1];
    end
  end

  assign ack_edge = ack_sync[1] ^ ack_prev;
  assign busy = req_tgl ^ ack_prev;
  assign commit = ack_edge && keep && !abort;  // see (R9) (R13)

  // Request side of the handshake; a late answer after an abort is dropped
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      req_tgl <= 1'b0;
      req_ch <= 1'b0;
      keep <= 1'b0;
    end else begin
      if (abort) begin
        keep <= 1'b0;  // see (R13)
      end else if (slot_begin && !busy) begin
        req_tgl <= ~req_tgl;
        req_ch <= cur_ch;
        keep <= 1'b1;
      end else if (ack_edge) begin
        keep <= 1'b0;
      end
    end
  end

  dtm_link dtm_link_inst (
    .adc_clk(adc_clk),
    .rst_b(rst_b),
    .req_tgl(req_tgl),
    .req_ch(req_ch),
    .adc_done(adc_done),
    .adc_data(adc_data),
    .adc_start(adc_start),
    .adc_chan(adc_chan),
    .res_data(res_data),
    .ack_tgl(link_ack)
  );

  assign res_whole = res_data[RES_W-1:FRAC_W];

  // Whole and fraction move in the same cycle, so a read never mixes runs
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      loc_whole <= TEMP_RESET;
      rem_whole <= TEMP_RESET;
      loc_frac <= TEMP_RESET;
      rem_frac <= TEMP_RESET;
    end else if (commit) begin
      if (req_ch) begin
        rem_whole <= res_whole;  // see (R22)
        rem_frac <= {res_data[FRAC_W-1:0], 6'h00};  // see (R23)
      end else begin
        loc_whole <= res_whole;  // see (R22)
        loc_frac <= {res_data[FRAC_W-1:0], 6'h00};  // see (R23)
      end
    end
  end

  // Limit checks: new results set flags, present values gate the clears
  assign loc_hot_new = commit && !req_ch && (res_whole > loc_lim);  // see (R16)
  assign rem_hot_new = commit && req_ch && (res_whole > rem_lim);  // see (R16)
  assign loc_over = loc_whole > loc_lim;
  assign rem_over = rem_whole > rem_lim;

  // Sticky flags and latched alert; a new hit wins over a clear
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_loc <= 1'b0;
      st_rem <= 1'b0;
      alert_oe <= 1'b0;
    end else begin
      st_loc <= loc_hot_new | (st_loc & ~(status_rd & ~loc_over));
      st_rem <= rem_hot_new | (st_rem & ~(status_rd & ~rem_over));
      alert_oe <= loc_hot_new | rem_hot_new |
                  (alert_oe & ~((status_rd & ~loc_over & ~rem_over) | ara_done));  // see (R21)
    end
  end
endmodule

/* dtm_chk.sv */
// Port-level assertions for the temperature monitor top
`timescale 1ns/1ps
module dtm_chk
  import dtm_pkg::*;
#(
  parameter int TIMEOUT_CYC = TIMEOUT_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic scl,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic alert_o,
  input wire logic alert_oe,
  input wire logic adc_clk,
  input wire logic adc_start,
  input wire logic adc_chan
);
  int lo_cnt;
  int hi_cnt;
  // Clock-low span and bus-idle span, in core cycles
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      lo_cnt <= 0;
      hi_cnt <= 0;
    end else begin
      lo_cnt <= scl ? 0 : lo_cnt + 1;
      hi_cnt <= (scl && sda_i) ? hi_cnt + 1 : 0;
    end
  end
  sda_low_only_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    !sda_o) else $error("data pin level not low");
  alert_low_only_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    !alert_o) else $error("alert pin level not low");
  reset_quiet_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    $rose(rst_b) |-> !sda_oe && !alert_oe) else $error("pins driven right after reset");
  ack_on_low_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    $changed(sda_oe) |-> !scl) else $error("data line changed while clock high");
  bus_timeout_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    lo_cnt > TIMEOUT_CYC + 8 |-> !sda_oe) else $error("data line held after timeout");
  alert_hold_a: assert property (@(posedge core_clk) disable iff (!rst_b)
    $fell(alert_oe) |-> hi_cnt < 40) else $error("alert cleared with no bus read");
  start_pulse_a: assert property (@(posedge adc_clk) disable iff (!rst_b)
    adc_start |=> !adc_start [*3]) else $error("start requests too close");
  chan_with_start_a: assert property (@(posedge adc_clk) disable iff (!rst_b)
    $changed(adc_chan) |-> adc_start) else $error("channel moved without a start");
endmodule
bind dtm_top dtm_chk #(.TIMEOUT_CYC(TIMEOUT_CYC)) dtm_chk_inst (
  .core_clk(core_clk), .rst_b(rst_b), .scl(scl), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe(sda_oe), .alert_o(alert_o), .alert_oe(alert_oe), .adc_clk(adc_clk),
  .adc_start(adc_start), .adc_chan(adc_chan));

/* dtm_conv_model.sv */
// Behavioural converter that answers start requests on the link clock
`timescale 1ns/1ps
module dtm_conv_model
  import dtm_pkg::*;
(
  input wire logic adc_clk,
  input wire logic adc_start,
  input wire logic adc_chan,
  output logic adc_done,
  output logic [RES_W-1:0] adc_data
);
  logic [RES_W-1:0] val_l = 10'h000;
  logic [RES_W-1:0] val_r = 10'h000;
  logic ch = 1'b0;
  int delay = 2;
  int wait_n = -1;
  int cnt_l = 0;
  int cnt_r = 0;
  // Answer after a set delay; data toggles outside the done cycle so stale values never match
  always @(posedge adc_clk) begin
    adc_done <= 1'b0;
    adc_data <= ~adc_data;
    if (adc_start) begin
      ch <= adc_chan;
      wait_n <= delay;
      cnt_l <= cnt_l + (adc_chan ? 0 : 1);
      cnt_r <= cnt_r + (adc_chan ? 1 : 0);
    end else if (wait_n == 0) begin
      adc_done <= 1'b1;
      adc_data <= ch ? val_r : val_l;
      wait_n <= -1;
    end else if (wait_n > 0) begin
      wait_n <= wait_n - 1;
    end
  end
  initial begin
    adc_done = 1'b0;
    adc_data = 10'h000;
  end
endmodule

/* tb_dtm_top.sv */
// Self-checking bench: host bus tasks on one side, converter model on the link
`timescale 1ns/1ps
module tb_dtm_top
  import dtm_pkg::*;
;
  localparam logic [6:0] A = 7'h4C;
  localparam int SC = 1500;
  localparam int H = 10;
  localparam logic [15:0] RV[10] = '{16'h0000, 16'h0100, 16'h1000, 16'h1100, 16'h0200,
    16'h0310, 16'h0546, 16'h0778, 16'hFE3C, 16'h0400};
  logic core_clk = 0;
  logic adc_clk = 0;
  logic rst_b = 0;
  logic scl = 1;
  logic hsda = 1;
  logic sda_o, sda_oe, alert_o, alert_oe, adc_start, adc_chan, adc_done;
  logic [RES_W-1:0] adc_data;
  logic [7:0] d;
  logic ak;
  int n_errors = 0;
  int tests_run = 0;
  wire sda = hsda & ~sda_oe; // Pull-up: a released line reads high
  always #5 core_clk = ~core_clk;
  always #62.5 adc_clk = ~adc_clk;
  // Identity value below is arbitrary
  dtm_top #(.SLAVE_ADDR(A), .ID_CODE(8'h3C), .SLOT_CYC(SC), .TIMEOUT_CYC(500)) dtm_top_inst (
    .core_clk(core_clk), .rst_b(rst_b), .scl(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .alert_o(alert_o), .alert_oe(alert_oe), .adc_clk(adc_clk),
    .adc_done(adc_done), .adc_data(adc_data), .adc_start(adc_start), .adc_chan(adc_chan));
  dtm_conv_model dtm_conv_model_inst (.adc_clk(adc_clk), .adc_start(adc_start),
    .adc_chan(adc_chan), .adc_done(adc_done), .adc_data(adc_data));
  task automatic tk(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // One bit; data moves two cycles after the clock falls so it never looks like start or stop
  task automatic bit_io(input logic b, output logic r);
    tk(2);
    hsda = b;
    tk(H);
    scl = 1;
    tk(H);
    r = sda;
    scl = 0;
  endtask
  task automatic start_c();
    tk(2);
    hsda = 1;
    tk(H);
    scl = 1;
    tk(H);
    hsda = 0;
    tk(H);
    scl = 0;
  endtask
  task automatic stop_c();
    tk(2);
    hsda = 0;
    tk(H);
    scl = 1;
    tk(H);
    hsda = 1;
    tk(H);
  endtask
  // Byte MSB first; the ninth clock carries the acknowledge
  task automatic put(input logic [7:0] v, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(v[i], r);
    bit_io(1'b1, r);
    a = ~r;
  endtask
  task automatic wr(input logic [7:0] c, input logic [7:0] v, input logic has_d);
    start_c();
    put({A, 1'b0}, ak);
    put(c, ak);
    if (has_d) put(v, ak);
    stop_c();
  endtask
  // Receive Byte from address a; the master ends it with a NACK
  task automatic rx(input logic [6:0] a, output logic [7:0] v);
    logic r;
    start_c();
    put({a, 1'b1}, ak);
    for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
    bit_io(1'b1, r);
    stop_c();
  endtask
  // Read Byte when has_c, otherwise Receive Byte on the kept pointer
  task automatic rd(input logic [7:0] c, input logic has_c, output logic [7:0] v);
    if (has_c) begin
      start_c();
      put({A, 1'b0}, ak);
      put(c, ak);
    end
    rx(A, v);
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chkb(input logic g, input logic e);
    chk({7'h00, g}, {7'h00, e});
  endtask
  task automatic rc(input logic [7:0] c, input logic [7:0] e);
    rd(c, 1'b1, d);
    chk(d, e);
  endtask
  // Clear before the command: its first start lands while the write is still finishing
  task automatic zc();
    dtm_conv_model_inst.cnt_l = 0;
    dtm_conv_model_inst.cnt_r = 0;
  endtask
  // Waits, then tests the model's start counters against limits
  task automatic cnt_in(input int n, input int ll, input int lh, input int rl, input int rh);
    tk(n);
    chkb(dtm_conv_model_inst.cnt_l inside {[ll:lh]} && dtm_conv_model_inst.cnt_r inside {[rl:rh]}, 1);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    // Tests need about 70,000 core cycles; this leaves some headroom
    #900_000;
    n_errors++;
    tally_and_finish();
  end
  initial begin
    tk(5);
    rst_b = 1;
    foreach (RV[i]) rc(RV[i][15:8], RV[i][7:0]);
    rc(REG_CFG_RD, 8'h10);
    rd(8'h00, 1'b0, d);
    chk(d, 8'h10);
    start_c();
    put({7'h2A, 1'b0}, ak);
    stop_c();
    chkb(ak, 1'b0);
    $display("test 1 done");
    wr(REG_CFG_WR, 8'h40, 1'b1);
    tk(SC);
    dtm_conv_model_inst.val_l = 10'h11D;
    dtm_conv_model_inst.val_r = 10'h0C2;
    zc();
    cnt_in(2 * SC, 0, 0, 0, 0);
    rc(REG_CFG_RD, 8'h40);
    rc(REG_LOC_WHOLE, 8'h00);
    $display("test 2 done");
    zc();
    wr(REG_ONE_SHOT, 8'h00, 1'b0);
    cnt_in(3 * SC, 1, 1, 1, 1);
    rc(REG_LOC_WHOLE, 8'h47);
    rc(REG_REM_WHOLE, 8'h30);
    rc(REG_LOC_FRAC, 8'h40);
    rc(REG_REM_FRAC, 8'h80);
    chkb(alert_oe, 1'b1);
    rc(REG_STATUS, 8'h40);
    chkb(alert_oe, 1'b1);
    wr(REG_LOC_LIM_WR, 8'h50, 1'b1);
    rc(REG_LOC_LIM_RD, 8'h50);
    wr(REG_ONE_SHOT, 8'h00, 1'b0);
    tk(3 * SC);
    rd(REG_STATUS, 1'b1, d);
    chk(d, 8'h40);
    chkb(alert_oe, 1'b0);
    $display("test 3 done");
    dtm_conv_model_inst.delay = 100;
    dtm_conv_model_inst.val_l = 10'h200;
    wr(REG_ONE_SHOT, 8'h00, 1'b0);
    wr(REG_CFG_WR, 8'h40, 1'b1);
    tk(3 * SC);
    rc(REG_LOC_WHOLE, 8'h47);
    dtm_conv_model_inst.delay = 2;
    $display("test 4 done");
    wr(REG_CFG_WR, 8'h00, 1'b1);
    tk(SC);
    zc();
    cnt_in(6 * SC, 2, 4, 2, 4);
    rc(REG_LOC_WHOLE, 8'h80);
    chkb(alert_oe, 1'b1);
    wr(REG_CFG_WR, 8'h20, 1'b1);
    tk(SC);
    zc();
    cnt_in(6 * SC, 0, 0, 5, 7);
    $display("test 5 done");
    wr(REG_CFG_WR, 8'h40, 1'b1);
    start_c();
    put({A, 1'b0}, ak);
    put(REG_CFG_RD, ak);
    start_c();
    put({A, 1'b1}, ak);
    tk(8);
    chkb(sda_oe, 1'b1);
    tk(600);
    chkb(sda_oe, 1'b0);
    stop_c();
    rc(REG_CFG_RD, 8'h40);
    rx(ALERT_RESP_ADDR, d);
    chkb(ak, 1'b1);
    chk(d, {A, 1'b0});
    chkb(alert_oe, 1'b0);
    $display("test 6 done");
    tally_and_finish();
  end
endmodule
